/* rtl/panel_mode_regs.vh */
// register map, field positions, reset values and timing of the panel mode controller
// assumes a 50 MHz system clock and a 32-bit classic Wishbone register port
`ifndef PANEL_MODE_REGS_VH
`define PANEL_MODE_REGS_VH
`define CTRL_OFS 8'h00
`define LAYER_OFS 8'h04
`define ROLE_LO_OFS 8'h08
`define ROLE_HI_OFS 8'h0C
`define STAT_OFS 8'h10
`define CTRL_ADDR_LSB 0
`define CTRL_PRIO_LSB 8
`define CTRL_METH_BIT 12
`define CTRL_DLAY_LSB 16
`define CTRL_DTGT_LSB 24
`define CTRL_RST 32'h0000_0001
`define LAYER_RST 8'hFF
`define ROLE_RST 24'h00_0000
`define ADDR_MIN 8'h01
`define ADDR_MAX 8'h80
`define ROLE_SRC 3'h0
`define ROLE_SSRC 3'h1
`define ROLE_TGT 3'h2
`define ROLE_STGT 3'h3
`define ROLE_MAC 3'h4
`define ROLE_SMAC 3'h5
`define ROLE_CAT 3'h6
`define REQ_SWITCH 2'h0
`define REQ_TARGET 2'h1
`define REQ_MACRO 2'h2
`define REQ_STORE 2'h3
`define EVERY_LAYER 4'h8
`define CLK_HZ 50000000
`define HOLD_MS 1000
`define HALF_MS 500
`define HOLD_CYC 26'h2FA_F080
`define HALF_CYC 25'h17D_7840
`endif

/* rtl/key_press_timer.v */
// classifies one function key press as short or long, reported at release
// assumes keyIn is debounced and synchronous to ref_clk
`timescale 1ns/1ps
module key_press_timer #(
    parameter [25:0] HOLD_CYC = 26'd50000000
) (
    input wire ref_clk,
    input wire rst_n,
    input wire keyIn,
    output reg shortPress,
    output reg longPress
);
    reg [25:0] cnt_r;
    reg keyPrev_r;
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_r <= 26'h000_0000;
            keyPrev_r <= 1'b0;
            shortPress <= 1'b0;
            longPress <= 1'b0;
        end else begin
            keyPrev_r <= keyIn;
            shortPress <= keyPrev_r && !keyIn && (cnt_r < HOLD_CYC);
            longPress <= keyPrev_r && !keyIn && (cnt_r >= HOLD_CYC);
            if (!keyIn)
                cnt_r <= 26'h000_0000;
            else if (cnt_r != HOLD_CYC)
                cnt_r <= cnt_r + 26'd1;
        end
    end
endmodule // key_press_timer

/* rtl/tick_gen.v */
// half-second tick and the matching blink level
// assumes one free-running system clock
`timescale 1ns/1ps
module tick_gen #(
    parameter [24:0] HALF_CYC = 25'd25000000
) (
    input wire ref_clk,
    input wire rst_n,
    output reg halfTick,
    output reg blink
);
    reg [24:0] cnt_r;
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_r <= 25'h000_0000;
            halfTick <= 1'b0;
            blink <= 1'b0;
        end else if (cnt_r == HALF_CYC - 25'd1) begin
            cnt_r <= 25'h000_0000;
            halfTick <= 1'b1;
            blink <= !blink;
        end else begin
            cnt_r <= cnt_r + 25'd1;
            halfTick <= 1'b0;
        end
    end
endmodule // tick_gen

/* rtl/panel_mode_ctrl.v */
// operating-mode controller of a routing panel: keys, modes, LEDs, requests
// assumes synchronous debounced keys, one-cycle data key and knob pulses,
// and a system controller that takes reqValid pulses without back-pressure
// Summary of operation
// - sixteen data keys, each with a configured three-bit role
// - function key held under one second is short, over is long
// - function keys toggle: same press class again turns the function off
// - direct mode is default; source key sends a switch request at once
// - in direct mode without layer select, layer LED off for every layer, blinks for breakaway
// - direct mode target key changes target, macro key runs macro
// - staging key enters staging, lit; sources load staged; commit switches
// - staging keeps every data key LED dark
// - short layer key enables layer select; knob then moves only the layer
// - staging with layer select loads source on the chosen layer only
// - one breakaway layer at most; none means every layer
// - long erase key after valid selection enters save; soft keys by kind
// - save LED blinks; ends on store or long press; short clears selection
// - short target-macro key toggles target select, lit; target taken at once
// - target select without staging lights target keys matching the controlled target
// - long target-macro key toggles macro select, blinks; commit runs macro
// - long commit key toggles alternate: swap sources each half second
// - panel address 1 to 128 must equal the rear switch
// - every-layer status by group or by default status layer, configurable
// - layers outside the layer list are never used as breakaway layer
// - after reset the default target group is controlled
`timescale 1ns/1ps
`include "panel_mode_regs.vh"
module panel_mode_ctrl #(
    parameter [25:0] HOLD_CYC = `HOLD_CYC,
    parameter [24:0] HALF_CYC = `HALF_CYC
) (
    input wire ref_clk,
    input wire rst_n,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    input wire wb_we_i,
    input wire [3:0] wb_sel_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    output reg wb_ack_o,
    input wire [5:0] fnKey,
    input wire [15:0] dataKeyPress,
    input wire knobStep,
    input wire knobDir,
    input wire [7:0] addrSwitch,
    input wire [31:0] layerStatus,
    output reg reqValid,
    output reg [1:0] reqKind,
    output reg [3:0] reqValue,
    output reg [3:0] reqLayer,
    output reg [3:0] reqTarget,
    output reg [5:0] fnLed,
    output reg [15:0] dataLed,
    output reg [7:0] panelAddr,
    output reg [1:0] panelPriority,
    output reg addrOk
);
    localparam FK_STAGE = 0;
    localparam FK_LAYER = 1;
    localparam FK_SAVE = 2;
    localparam FK_TM = 3;
    localparam FK_COMMIT = 4;

    // ----------------------------------------
    // registers and mode state
    // ----------------------------------------
    reg [31:0] ctrl_r;
    reg [7:0] layerList_r;
    reg [23:0] roleLo_r;
    reg [23:0] roleHi_r;
    reg stage_r, layerMode_r, save_r, tgtSel_r, macSel_r, alt_r;
    reg boot_r;
    reg [3:0] layerPos_r;
    reg [3:0] target_r, online_r, staged_r, macro_r;
    reg stagedOk_r, macroOk_r;
    wire [5:0] shortP;
    wire [5:0] longP;
    wire halfTick, blink;

    // ----------------------------------------
    // key timing and blink
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : fk
            key_press_timer #(.HOLD_CYC(HOLD_CYC)) u_kt (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .keyIn(fnKey[g]),
                .shortPress(shortP[g]),
                .longPress(longP[g])
            );
        end
    endgenerate

    tick_gen #(.HALF_CYC(HALF_CYC)) u_tick (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .halfTick(halfTick),
        .blink(blink)
    );

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire [47:0] roles = {roleHi_r, roleLo_r};
    wire direct = !(stage_r || save_r || tgtSel_r || macSel_r || alt_r);
    wire breakaway = !layerPos_r[3] && layerList_r[layerPos_r[2:0]];
    wire [3:0] layerEff = breakaway ? layerPos_r : `EVERY_LAYER;
    wire [2:0] dfltLay = ctrl_r[`CTRL_DLAY_LSB +: 3];
    wire selOk = stagedOk_r || tgtSel_r || (macSel_r && macroOk_r);
    reg [3:0] keyIdx;
    reg keyHit;
    reg [2:0] role;
    reg [3:0] nxtLayer;
    reg [3:0] srch;
    reg found;
    reg [3:0] statSrc;
    integer i, j, k;

    function [3:0] stepPos;
        input [3:0] p;
        input up;
        begin
            if (up)
                stepPos = (p == 4'h8) ? 4'h0 : p + 4'h1;
            else
                stepPos = (p == 4'h0) ? 4'h8 : p - 4'h1;
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] sel;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1)
                if (sel[b])
                    merge[b*8 +: 8] = nw[b*8 +: 8];
        end
    endfunction

    always @* begin
        keyIdx = 4'h0;
        keyHit = 1'b0;
        for (j = 15; j >= 0; j = j - 1)
            if (dataKeyPress[j]) begin
                keyIdx = j[3:0];
                keyHit = 1'b1;
            end
        role = roles[keyIdx*3 +: 3];
    end

    // knob walks only over listed layers plus the every-layer position
    always @* begin
        nxtLayer = layerPos_r;
        srch = layerPos_r;
        found = 1'b0;
        for (k = 0; k < 9; k = k + 1) begin
            srch = stepPos(srch, knobDir);
            if (!found && (srch[3] || layerList_r[srch[2:0]])) begin
                nxtLayer = srch;
                found = 1'b1;
            end
        end
    end

    always @* begin
        if (!layerEff[3])
            statSrc = layerStatus[layerEff[2:0]*4 +: 4];
        else if (ctrl_r[`CTRL_METH_BIT])
            statSrc = layerStatus[dfltLay*4 +: 4];
        else
            statSrc = online_r;
    end

    // ----------------------------------------
    // Wishbone slave
    // ----------------------------------------
    wire wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire [31:0] statWord = {2'h0, macroOk_r, macro_r, stagedOk_r, staged_r,
        online_r, target_r, layerPos_r, addrOk, direct, alt_r, macSel_r,
        tgtSel_r, save_r, layerMode_r, stage_r};
    wire [31:0] roleLoNew = merge({8'h00, roleLo_r}, wb_dat_i, wb_sel_i);
    wire [31:0] roleHiNew = merge({8'h00, roleHi_r}, wb_dat_i, wb_sel_i);

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            ctrl_r <= `CTRL_RST;
            layerList_r <= `LAYER_RST;
            roleLo_r <= `ROLE_RST;
            roleHi_r <= `ROLE_RST;
        end else begin
            wb_ack_o <= wbReq;
            wb_dat_o <= 32'h0000_0000;
            if (wbReq) begin
                case (wb_adr_i)
                    `CTRL_OFS: wb_dat_o <= ctrl_r;
                    `LAYER_OFS: wb_dat_o <= {24'h00_0000, layerList_r};
                    `ROLE_LO_OFS: wb_dat_o <= {8'h00, roleLo_r};
                    `ROLE_HI_OFS: wb_dat_o <= {8'h00, roleHi_r};
                    `STAT_OFS: wb_dat_o <= statWord;
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
                if (wb_we_i) begin
                    case (wb_adr_i)
                        `CTRL_OFS: ctrl_r <= merge(ctrl_r, wb_dat_i, wb_sel_i);
                        `LAYER_OFS: if (wb_sel_i[0]) layerList_r <= wb_dat_i[7:0];
                        `ROLE_LO_OFS: roleLo_r <= roleLoNew[23:0];
                        `ROLE_HI_OFS: roleHi_r <= roleHiNew[23:0];
                        default: ;
                    endcase
                end
            end
        end
    end

    // ----------------------------------------
    // modes and requests
    // ----------------------------------------
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            stage_r <= 1'b0;
            layerMode_r <= 1'b0;
            save_r <= 1'b0;
            tgtSel_r <= 1'b0;
            macSel_r <= 1'b0;
            alt_r <= 1'b0;
            boot_r <= 1'b1;
            layerPos_r <= `EVERY_LAYER;
            target_r <= 4'h0;
            online_r <= 4'h0;
            staged_r <= 4'h0;
            macro_r <= 4'h0;
            stagedOk_r <= 1'b0;
            macroOk_r <= 1'b0;
            reqValid <= 1'b0;
            reqKind <= `REQ_SWITCH;
            reqValue <= 4'h0;
            reqLayer <= `EVERY_LAYER;
            reqTarget <= 4'h0;
        end else begin
            reqValid <= 1'b0;
            boot_r <= 1'b0;
            if (boot_r)
                target_r <= ctrl_r[`CTRL_DTGT_LSB +: 4];
            if (knobStep && layerMode_r)
                layerPos_r <= nxtLayer;
            if (shortP[FK_LAYER])
                layerMode_r <= !layerMode_r;
            // one request per cycle: alternate tick, then function keys, then data keys
            if (alt_r && halfTick) begin
                reqValid <= 1'b1;
                reqKind <= `REQ_SWITCH;
                reqValue <= staged_r;
                reqLayer <= layerEff;
                reqTarget <= target_r;
                staged_r <= online_r;
                online_r <= staged_r;
            end else if (shortP[FK_STAGE]) begin
                stage_r <= !stage_r;
            end else if (longP[FK_SAVE]) begin
                if (save_r)
                    save_r <= 1'b0;
                else if (selOk)
                    save_r <= 1'b1;
            end else if (shortP[FK_SAVE]) begin
                stagedOk_r <= 1'b0;
                macroOk_r <= 1'b0;
            end else if (shortP[FK_TM]) begin
                tgtSel_r <= !tgtSel_r;
                macSel_r <= 1'b0;
            end else if (longP[FK_TM]) begin
                macSel_r <= !macSel_r;
                tgtSel_r <= 1'b0;
            end else if (longP[FK_COMMIT]) begin
                alt_r <= !alt_r && stagedOk_r;
            end else if (shortP[FK_COMMIT]) begin
                if (alt_r)
                    alt_r <= 1'b0;
                else if (macSel_r && macroOk_r) begin
                    reqValid <= 1'b1;
                    reqKind <= `REQ_MACRO;
                    reqValue <= macro_r;
                end else if (stagedOk_r) begin
                    reqValid <= 1'b1;
                    reqKind <= `REQ_SWITCH;
                    reqValue <= staged_r;
                    reqLayer <= layerEff;
                    reqTarget <= target_r;
                    staged_r <= online_r;
                    online_r <= staged_r;
                end
            end else if (keyHit) begin
                case (role)
                    `ROLE_SRC, `ROLE_SSRC: begin
                        if (save_r && role == `ROLE_SSRC && stagedOk_r) begin
                            reqValid <= 1'b1;
                            reqKind <= `REQ_STORE;
                            reqValue <= keyIdx;
                            reqTarget <= staged_r;
                            save_r <= 1'b0;
                        end else if (stage_r && !save_r) begin
                            staged_r <= keyIdx;
                            stagedOk_r <= 1'b1;
                            reqLayer <= layerMode_r ? layerEff : `EVERY_LAYER;
                        end else if (direct) begin
                            reqValid <= 1'b1;
                            reqKind <= `REQ_SWITCH;
                            reqValue <= keyIdx;
                            reqLayer <= layerEff;
                            reqTarget <= target_r;
                            online_r <= keyIdx;
                        end
                    end
                    `ROLE_TGT, `ROLE_STGT: begin
                        if (save_r && role == `ROLE_STGT) begin
                            reqValid <= 1'b1;
                            reqKind <= `REQ_STORE;
                            reqValue <= keyIdx;
                            reqTarget <= target_r;
                            save_r <= 1'b0;
                        end else if (direct || tgtSel_r) begin
                            target_r <= keyIdx;
                            reqValid <= 1'b1;
                            reqKind <= `REQ_TARGET;
                            reqValue <= keyIdx;
                            reqTarget <= keyIdx;
                        end
                    end
                    `ROLE_MAC, `ROLE_SMAC: begin
                        if (save_r && role == `ROLE_SMAC && macroOk_r) begin
                            reqValid <= 1'b1;
                            reqKind <= `REQ_STORE;
                            reqValue <= keyIdx;
                            reqTarget <= macro_r;
                            save_r <= 1'b0;
                        end else if (macSel_r) begin
                            macro_r <= keyIdx;
                            macroOk_r <= 1'b1;
                        end else if (direct) begin
                            reqValid <= 1'b1;
                            reqKind <= `REQ_MACRO;
                            reqValue <= keyIdx;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // ----------------------------------------
    // LEDs and configuration outputs
    // ----------------------------------------
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            fnLed <= 6'h00;
            dataLed <= 16'h0000;
            panelAddr <= `ADDR_MIN;
            panelPriority <= 2'h0;
            addrOk <= 1'b0;
        end else begin
            fnLed[FK_STAGE] <= stage_r;
            fnLed[FK_LAYER] <= layerMode_r || (breakaway && blink);
            fnLed[FK_SAVE] <= save_r && blink;
            fnLed[FK_TM] <= tgtSel_r || (macSel_r && blink);
            fnLed[FK_COMMIT] <= alt_r && blink;
            fnLed[5] <= 1'b0;
            for (i = 0; i < 16; i = i + 1) begin
                if (stage_r || macSel_r)
                    dataLed[i] <= 1'b0;
                else if (tgtSel_r)
                    dataLed[i] <= (roles[i*3 +: 3] == `ROLE_TGT || roles[i*3 +: 3] == `ROLE_STGT)
                        && target_r == i[3:0];
                else
                    dataLed[i] <= direct && (roles[i*3 +: 3] == `ROLE_SRC || roles[i*3 +: 3] == `ROLE_SSRC)
                        && statSrc == i[3:0];
            end
            panelAddr <= ctrl_r[`CTRL_ADDR_LSB +: 8];
            panelPriority <= ctrl_r[`CTRL_PRIO_LSB +: 2];
            addrOk <= ctrl_r[7:0] >= `ADDR_MIN && ctrl_r[7:0] <= `ADDR_MAX
                && ctrl_r[7:0] == addrSwitch;
        end
    end
endmodule // panel_mode_ctrl

/* dv/system_ctrl_model.sv */
// behavioural system controller: keeps the per-layer source status from requests
// assumes requests arrive as one-cycle reqValid pulses with no back-pressure
`timescale 1ns/1ps
module system_ctrl_model (
    input wire ref_clk,
    input wire rst_n,
    input wire reqValid,
    input wire [1:0] reqKind,
    input wire [3:0] reqValue,
    input wire [3:0] reqLayer,
    output reg [31:0] layerStatus
);
    integer i;
    // only switches move status; no protect or lock is ever set here,
    // so panel priority never has to gate a request
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            layerStatus <= 32'h0000_0000;
        end else if (reqValid && reqKind == 2'h0) begin
            for (i = 0; i < 8; i = i + 1) begin
                if (reqLayer == 4'h8 || reqLayer == i[3:0]) layerStatus[4*i +: 4] <= reqValue;
            end
        end
    end
endmodule // system_ctrl_model

/* dv/panel_mode_monitor.sv */
// assertions on the ports of the panel mode controller
// assumes a single ref_clk domain with synchronous active-low reset
`timescale 1ns/1ps
module panel_mode_monitor #(
    parameter [25:0] HOLD_CYC = 26'h00_0014
) (
    input wire ref_clk,
    input wire rst_n,
    input wire [31:0] wb_dat_o,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire [5:0] fnKey,
    input wire [5:0] fnLed,
    input wire [15:0] dataLed,
    input wire [7:0] addrSwitch,
    input wire [7:0] panelAddr,
    input wire [1:0] panelPriority,
    input wire addrOk,
    input wire reqValid,
    input wire [3:0] reqLayer
);
    reg [25:0] holdCnt_r;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // saturating hold length of the staging key, read at its release
    always @(posedge ref_clk) begin
        if (!rst_n || !fnKey[0]) holdCnt_r <= 26'h000_0000;
        else if (holdCnt_r != 26'h3FF_FFFF) holdCnt_r <= holdCnt_r + 26'h000_0001;
    end
    property p_ackNext; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ackNext: assert property (p_ackNext) else $error("bus request not acknowledged next cycle");
    property p_ackOne; wb_ack_o |=> !wb_ack_o; endproperty
    a_ackOne: assert property (p_ackOne) else $error("ack longer than one cycle");
    property p_datZero; !wb_ack_o |-> wb_dat_o == 32'h0000_0000; endproperty
    a_datZero: assert property (p_datZero) else $error("read data not zero outside ack");
    property p_addrMatch; (addrSwitch == panelAddr && panelAddr >= 8'h01 && panelAddr <= 8'h80) [*3] |-> addrOk;
    endproperty
    a_addrMatch: assert property (p_addrMatch) else $error("address match not flagged");
    property p_addrMiss; (addrSwitch != panelAddr) [*3] |-> !addrOk; endproperty
    a_addrMiss: assert property (p_addrMiss) else $error("address mismatch flagged as good");
    property p_stageDark; fnLed[0] [*2] |-> dataLed == 16'h0000; endproperty
    a_stageDark: assert property (p_stageDark) else $error("data key lit while staging");
    property p_shortStage; $fell(fnKey[0]) && holdCnt_r < HOLD_CYC && !fnLed[0] |-> ##[2:4] fnLed[0];
    endproperty
    a_shortStage: assert property (p_shortStage) else $error("short staging press ignored");
    property p_resetOut;
        $rose(rst_n) |-> fnLed == 6'h00 && !reqValid && reqLayer == 4'h8 && panelAddr == 8'h01 && panelPriority == 2'h0;
    endproperty
    a_resetOut: assert property (p_resetOut) else $error("outputs wrong after reset");
endmodule // panel_mode_monitor
bind panel_mode_ctrl panel_mode_monitor #(.HOLD_CYC(HOLD_CYC)) i_panel_mode_monitor (.ref_clk, .rst_n, .wb_dat_o,
    .wb_cyc_i, .wb_stb_i, .wb_ack_o, .fnKey, .fnLed, .dataLed, .addrSwitch, .panelAddr, .panelPriority, .addrOk,
    .reqValid, .reqLayer);

/* dv/test_panel_mode_ctrl.sv */
// self-checking bench of the panel mode controller with a controller model
// assumes shortened hold and half-second counts so the run stays brief
`timescale 1ns/1ps
module test_panel_mode_ctrl;
    localparam [25:0] HOLD = 26'h00_0014;
    localparam [24:0] HALF = 25'h00_000A;
    reg ref_clk = 1'b0;
    reg rst_n = 1'b0;
    reg [7:0] wbAdr = 8'h00;
    reg [31:0] wbDatI = 32'h0000_0000;
    reg wbWe = 1'b0;
    reg wbCyc = 1'b0;
    reg wbStb = 1'b0;
    reg [5:0] fnKey = 6'h00;
    reg [15:0] dataKeyPress = 16'h0000;
    reg knobStep = 1'b0;
    reg [7:0] addrSwitch = 8'h01;
    wire [31:0] wbDatO, layerStatus;
    wire wbAck, reqValid, addrOk;
    wire [1:0] reqKind, panelPriority;
    wire [3:0] reqValue, reqLayer, reqTarget;
    wire [5:0] fnLed;
    wire [15:0] dataLed;
    wire [7:0] panelAddr;
    reg [31:0] expRd[$];
    reg [13:0] expReq[$];
    reg [13:0] expR;
    reg [31:0] seed = 32'hec19;
    reg [31:0] wdat;
    reg altOn = 1'b0;
    reg [3:0] altVal = 4'h0;
    integer altGap = 0;
    integer failCount = 0;
    integer comparisons = 0;
    always #10 ref_clk = ~ref_clk;
    panel_mode_ctrl #(.HOLD_CYC(HOLD), .HALF_CYC(HALF)) i_panel_mode_ctrl (.ref_clk(ref_clk), .rst_n(rst_n),
        .wb_adr_i(wbAdr), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_we_i(wbWe), .wb_sel_i(4'hF), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_ack_o(wbAck), .fnKey(fnKey), .dataKeyPress(dataKeyPress), .knobStep(knobStep),
        .knobDir(1'b1), .addrSwitch(addrSwitch), .layerStatus(layerStatus), .reqValid(reqValid), .reqKind(reqKind),
        .reqValue(reqValue), .reqLayer(reqLayer), .reqTarget(reqTarget), .fnLed(fnLed), .dataLed(dataLed),
        .panelAddr(panelAddr), .panelPriority(panelPriority), .addrOk(addrOk));
    system_ctrl_model i_system_ctrl_model (.ref_clk(ref_clk), .rst_n(rst_n), .reqValid(reqValid), .reqKind(reqKind),
        .reqValue(reqValue), .reqLayer(reqLayer), .layerStatus(layerStatus));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task check(input [8*10-1:0] what, input [31:0] exp, input [31:0] got);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                failCount = failCount + 1;
                $display("mismatch %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task stop_test;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, failCount);
            if (failCount == 0 && comparisons > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    task wbXfer(input we, input [7:0] adr, input [31:0] dat);
        begin
            {wbCyc, wbStb, wbWe, wbAdr, wbDatI} <= {2'b11, we, adr, dat};
            @(posedge ref_clk);
            while (wbAck !== 1'b1) @(posedge ref_clk);
            {wbCyc, wbStb} <= 2'b00;
            @(posedge ref_clk);
        end
    endtask
    task wbRd(input [7:0] adr, input [31:0] exp);
        begin
            expRd.push_back(exp);
            wbXfer(1'b0, adr, 32'h0000_0000);
        end
    endtask
    task fnPress(input integer k, input integer hold);
        begin
            fnKey[k] <= 1'b1;
            repeat (hold) @(posedge ref_clk);
            fnKey[k] <= 1'b0;
            repeat (6) @(posedge ref_clk);
        end
    endtask
    task tapKey(input integer k, input hasReq, input [13:0] exp);
        begin
            if (hasReq) expReq.push_back(exp);
            dataKeyPress <= 16'h0001 << k;
            @(posedge ref_clk);
            dataKeyPress <= 16'h0000;
            repeat (4) @(posedge ref_clk);
        end
    endtask
    // ----------------------------------------
    // result watcher
    // ----------------------------------------
    always @(posedge ref_clk) begin
        if (wbAck === 1'b1 && !wbWe) begin
            if (expRd.size() == 0) check("spareRead", 32'h0000_0000, 32'h0000_0001);
            else check("readData", expRd.pop_front(), wbDatO);
        end
        if (reqValid === 1'b1 && altOn) begin
            check("altValue", {28'h000_0000, altVal}, {28'h000_0000, reqValue});
            if (altGap != 0) check("altGap", {7'h00, HALF}, altGap);
            altVal = altVal ^ 4'h7;
            altGap = 1;
        end else if (reqValid === 1'b1) begin
            if (expReq.size() == 0) check("spareReq", 32'h0000_0000, 32'h0000_0001);
            else begin
                expR = expReq.pop_front();
                check("reqFields", {22'h00_0000, expR[13:4]}, {22'h00_0000, reqKind, reqValue, reqLayer});
                if (expR[13:12] == 2'h0) check("reqTarget", {28'h000_0000, expR[3:0]}, {28'h000_0000, reqTarget});
            end
        end else if (altGap != 0) altGap = altGap + 1;
    end
    initial begin
        repeat (6000) @(posedge ref_clk);
        failCount = failCount + 1;
        stop_test;
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        wbRd(8'h00, 32'h0000_0001);
        wbRd(8'h04, 32'h0000_00FF);
        wbRd(8'h10, 32'h0000_08C0);
        wbXfer(1'b1, 8'h14, 32'hFFFF_FFFF);
        wbRd(8'h14, 32'h0000_0000);
        wdat = $random(seed);
        wdat[7:0] = {1'b0, wdat[6:0]} + 8'h01;
        addrSwitch <= wdat[7:0];
        wbXfer(1'b1, 8'h00, wdat);
        wbRd(8'h00, wdat);
        check("panelAddr", {24'h00_0000, wdat[7:0]}, {24'h00_0000, panelAddr});
        wbXfer(1'b1, 8'h08, 32'h001A_B310);
        wbRd(8'h08, 32'h001A_B310);
        tapKey(0, 1'b1, 14'h0080);
        tapKey(3, 1'b1, 14'h0380);
        tapKey(1, 1'b1, 14'h1180);
        tapKey(7, 1'b1, 14'h0781);
        tapKey(2, 1'b1, 14'h2280);
        tapKey(5, 1'b1, 14'h2580);
        tapKey(6, 1'b0, 14'h0000);
        tapKey(4, 1'b1, 14'h1480);
        tapKey(0, 1'b1, 14'h0084);
        wbXfer(1'b1, 8'h04, 32'h0000_00FE);
        fnPress(1, 3);
        check("layerLed", 32'h0000_0001, {31'h0000_0000, fnLed[1]});
        knobStep <= 1'b1;
        @(posedge ref_clk);
        knobStep <= 1'b0;
        repeat (3) @(posedge ref_clk);
        tapKey(0, 1'b1, 14'h0014);
        fnPress(1, 3);
        tapKey(0, 1'b1, 14'h0014);
        fnPress(0, 3);
        check("stageLed", 32'h0000_0001, {31'h0000_0000, fnLed[0]});
        check("dataLed", 32'h0000_0000, {16'h0000, dataLed});
        tapKey(7, 1'b0, 14'h0000);
        expReq.push_back(14'h0714);
        fnPress(4, 3);
        altOn <= 1'b1;
        fnPress(4, HOLD + 26'h00_0003);
        fnKey[4] <= 1'b1;
        repeat (HOLD + 26'h00_0003) @(posedge ref_clk);
        while (reqValid !== 1'b1) @(posedge ref_clk);
        fnKey[4] <= 1'b0;
        repeat (6) @(posedge ref_clk);
        altOn <= 1'b0;
        repeat (30) @(posedge ref_clk);
        check("altLed", 32'h0000_0000, {31'h0000_0000, fnLed[4]});
        check("leftNotes", 32'h0000_0000, expReq.size() + expRd.size());
        stop_test;
    end
endmodule // test_panel_mode_ctrl
